// >>> verification/bsg_gpio_bench.sv
/*
 * Self-checking bench for the bus shared GPIO ports.
 * Assumes the design files under verilog/ and the pin model.
 */
`timescale 1ns/10ps
`include "bsg_regs.svh"

module bsg_gpio_bench;
    logic i_clk, i_nrst, i_por, hsel, hwrite, wide, ale, doe, ext_oe;
    logic hreadyout, hresp, ebd;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] baddr, bwdata, brdata, ext;
    logic [7:0] lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe;
    int fail_count, n_tests, cycles;

    // ************************************************************
    // Design and far side
    // ************************************************************
    bsg_gpio bsg_gpio_inst
    (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por(i_por), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hready(hreadyout), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_bus_wide(wide), .i_bus_ale(ale), .i_bus_addr(baddr),
        .i_bus_wdata(bwdata), .i_bus_data_oe(doe), .o_bus_rdata(brdata),
        .o_external_bus_disable(ebd), .i_low_port_pin_n(lo_in),
        .o_low_port_pin_n(lo_out), .o_low_port_pin_n_oe(lo_oe),
        .i_high_port_pin_n(hi_in), .o_high_port_pin_n(hi_out),
        .o_high_port_pin_n_oe(hi_oe)
    );
    bsg_pins_model lo_pins_inst
    (
        .i_clk(i_clk), .i_dev(lo_out), .i_dev_oe(lo_oe), .i_ext(ext[7:0]),
        .i_ext_oe(ext_oe), .o_level(lo_in)
    );
    bsg_pins_model hi_pins_inst
    (
        .i_clk(i_clk), .i_dev(hi_out), .i_dev_oe(hi_oe),
        .i_ext(ext[15:8]), .i_ext_oe(ext_oe), .o_level(hi_in)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One AHB-Lite single word; waits on hready in both phases
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= `BSG_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge i_clk);
        while (hreadyout !== 1'b1) @(posedge i_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge i_clk);
        while (hreadyout !== 1'b1) @(posedge i_clk);
        rd = hrdata;
    endtask

    // Whole cycles; at the edge outputs still show what earlier edges
    // launched, and inputs change there by non-blocking assignment
    task wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task do_reset(input logic por);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        i_por <= por;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        i_por <= 1'b0;
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Power-on state: bus owns pins, directions all inputs
    task t_reset;
        ahb(1'b0, `BSG_OFS_LOW_DIR, 32'h0);
        chk(rd, 32'hff);
        ahb(1'b0, `BSG_OFS_HIGH_DIR, 32'h0);
        chk(rd, 32'hff);
        ahb(1'b0, `BSG_OFS_MEM_CTRL, 32'h0);
        chk(rd, 32'h00);
        chk(ebd, 1'b0);
        chk({hi_out, lo_out, hi_oe, lo_oe}, 32'h1234ffff);
        $display("reset test done");
    endtask

    // Both ports as GPIO: mixed direction, latch and pin reads
    task t_gpio;
        logic [7:0] b, d;
        ahb(1'b1, `BSG_OFS_MEM_CTRL, 32'hff);
        ahb(1'b0, `BSG_OFS_MEM_CTRL, 32'h0);
        chk(rd, 32'hf3);
        chk(ebd, 1'b1);
        ext <= 16'h3c3c;
        for (int p = 0; p < 2; p++)
        begin
            b = p ? `BSG_OFS_HIGH_PINS : `BSG_OFS_LOW_PINS;
            d = 8'ha5 ^ p[7:0];
            ahb(1'b1, b + 8'h04, {24'h0, d});
            ahb(1'b1, b + 8'h08, 32'h0f);
            wt(4);
            chk(p ? hi_oe : lo_oe, 8'hf0);
            chk((p ? hi_out : lo_out) & 8'hf0, d & 8'hf0);
            ahb(1'b0, b, 32'h0);
            chk(rd, {24'h0, (d & 8'hf0) | 8'h0c});
            ahb(1'b0, b + 8'h04, 32'h0);
            chk(rd, {24'h0, d});
            chk({hresp, hreadyout}, 2'b01);
            ahb(1'b1, b, 32'h5a);
            ahb(1'b0, b + 8'h04, 32'h0);
            chk(rd, 32'h5a);
        end
        $display("gpio test done");
    endtask

    // System bus use: multiplexed and address-only lanes
    task t_bus;
        ahb(1'b1, `BSG_OFS_MEM_CTRL, 32'h00);
        wide <= 1'b1;
        ale <= 1'b1;
        wt(3);
        chk({hi_out, lo_out, hi_oe, lo_oe}, 32'h1234ffff);
        ale <= 1'b0;
        doe <= 1'b1;
        wt(3);
        chk({hi_out, lo_out, hi_oe, lo_oe}, 32'habcdffff);
        doe <= 1'b0;
        ext <= 16'h8877;
        wt(5);
        chk({hi_oe, lo_oe}, 16'h0000);
        chk(brdata, 16'h8877);
        ahb(1'b0, `BSG_OFS_LOW_DIR, 32'h0);
        chk(rd, 32'h0f);
        ahb(1'b0, `BSG_OFS_HIGH_LATCH, 32'h0);
        chk(rd, 32'h5a);
        wide <= 1'b0;
        baddr <= 16'h5678;
        wt(3);
        chk({hi_out, lo_out, hi_oe, lo_oe}, 32'h5678ffff);
        $display("bus test done");
    endtask

    // Warm reset keeps latches; power-on reset clears them
    task t_rst;
        do_reset(1'b0);
        ahb(1'b0, `BSG_OFS_LOW_LATCH, 32'h0);
        chk(rd, 32'h5a);
        ahb(1'b0, `BSG_OFS_LOW_DIR, 32'h0);
        chk(rd, 32'hff);
        do_reset(1'b1);
        ahb(1'b0, `BSG_OFS_HIGH_LATCH, 32'h0);
        chk(rd, 32'h00);
        $display("reset source test done");
    endtask

    // ************************************************************
    // Clock, timeout and main sequence
    // ************************************************************
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        i_nrst = 1'b0;
        i_por = 1'b1;
        {hsel, hwrite, ale, doe} = 4'h0;
        wide = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        baddr = 16'h1234;
        bwdata = 16'habcd;
        ext = 16'h0000;
        ext_oe = 1'b1;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        i_por <= 1'b0;
        wt(2);
        t_reset();
        t_gpio();
        t_bus();
        t_rst();
        tally_and_finish();
    end
endmodule

// >>> verification/bsg_pins_model.sv
/*
 * Far side of one 8-bit shared port: external memory or peripherals.
 * Assumes one driver per bit at a time; device enable wins when high.
 */
`timescale 1ns/10ps

module bsg_pins_model
(
    input wire logic i_clk,
    input wire logic [7:0] i_dev,
    input wire logic [7:0] i_dev_oe,
    input wire logic [7:0] i_ext,
    input wire logic i_ext_oe,
    output logic [7:0] o_level
);
    logic [7:0] flt_reg = 8'h00;
    logic [7:0] ext_en;

    // ************************************************************
    // Wire level
    // ************************************************************
    // Undriven bits toggle every cycle, so a stale value never reads back
    assign ext_en = ~i_dev_oe & {8{i_ext_oe}};
    assign o_level = (i_dev & i_dev_oe) | (i_ext & ext_en)
        | (flt_reg & ~i_dev_oe & ~{8{i_ext_oe}});

    // Floating pattern: inverse of the last level on the wire
    always_ff @(posedge i_clk)
    begin
        flt_reg <= ~o_level;
    end
endmodule

// >>> verilog/bsg_gpio.sv
/*
 * Two 8-bit bus shared GPIO ports with direction, latch and pin registers
 * behind an AHB-Lite slave, and the memory bus control register.
 * Assumes a single AHB-Lite master, an external bus controller on i_clk
 * supplying address/data, and i_por high during power-on/brown-out reset.
 */
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "bsg_regs.svh"

module bsg_gpio
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_por,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_bus_wide,
    input wire logic i_bus_ale,
    input wire logic [15:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    input wire logic i_bus_data_oe,
    output logic [15:0] o_bus_rdata,
    output logic o_external_bus_disable,
    input wire logic [7:0] i_low_port_pin_n,
    output logic [7:0] o_low_port_pin_n,
    output logic [7:0] o_low_port_pin_n_oe,
    input wire logic [7:0] i_high_port_pin_n,
    output logic [7:0] o_high_port_pin_n,
    output logic [7:0] o_high_port_pin_n_oe
);
    import bsg_pkg::*;

    bsg_top_s st_reg;
    bsg_top_s st_next;
    logic acc;
    logic resp_reg;
    bsg_port_if lo_if ();
    bsg_port_if hi_if ();

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Bus drive of one byte lane: {enable, data}
    function automatic logic [15:0] bus_lane(input logic hi,
        input logic wide, input logic ale, input logic [15:0] addr,
        input logic [15:0] wdata, input logic data_oe);
        logic [7:0] a;
        logic [7:0] d;
        a = hi ? addr[15:8] : addr[7:0];
        d = hi ? wdata[15:8] : wdata[7:0];
        if (!wide || ale)
        begin
            bus_lane = {8'hff, a};
        end
        else
        begin
            bus_lane = {{8{data_oe}}, d};
        end
    endfunction

    // Read mux; uses the next state so a write just before is seen
    function automatic logic [7:0] rd_val(input logic [7:0] a,
        input bsg_top_s s, input logic [7:0] plo, input logic [7:0] phi);
        if (a == `BSG_OFS_LOW_PINS)
        begin
            rd_val = plo;
        end
        else if (a == `BSG_OFS_LOW_LATCH)
        begin
            rd_val = s.lat_lo;
        end
        else if (a == `BSG_OFS_LOW_DIR)
        begin
            rd_val = s.dir_lo;
        end
        else if (a == `BSG_OFS_HIGH_PINS)
        begin
            rd_val = phi;
        end
        else if (a == `BSG_OFS_HIGH_LATCH)
        begin
            rd_val = s.lat_hi;
        end
        else if (a == `BSG_OFS_HIGH_DIR)
        begin
            rd_val = s.dir_hi;
        end
        else if (a == `BSG_OFS_MEM_CTRL)
        begin
            rd_val = s.mctl & `BSG_MCTL_WMASK;
        end
        else
        begin
            rd_val = 8'h00;
        end
    endfunction

    // ****************************************************************
    // AHB-Lite slave and registers
    // ****************************************************************
    assign acc = i_hsel && i_hready && i_htrans[`BSG_HTRANS_ACTIVE_BIT];

    // Data phase write first, then address phase capture
    always_comb
    begin
        st_next = st_reg;
        if (st_reg.wr_pend)
        begin
            if (st_reg.wr_addr == `BSG_OFS_LOW_PINS ||
                st_reg.wr_addr == `BSG_OFS_LOW_LATCH)
            begin
                st_next.lat_lo = i_hwdata[7:0];
            end
            else if (st_reg.wr_addr == `BSG_OFS_LOW_DIR)
            begin
                st_next.dir_lo = i_hwdata[7:0];
            end
            else if (st_reg.wr_addr == `BSG_OFS_HIGH_PINS ||
                st_reg.wr_addr == `BSG_OFS_HIGH_LATCH)
            begin
                st_next.lat_hi = i_hwdata[7:0];
            end
            else if (st_reg.wr_addr == `BSG_OFS_HIGH_DIR)
            begin
                st_next.dir_hi = i_hwdata[7:0];
            end
            else if (st_reg.wr_addr == `BSG_OFS_MEM_CTRL)
            begin
                st_next.mctl = i_hwdata[7:0] & `BSG_MCTL_WMASK;
            end
        end
        st_next.wr_pend = acc && i_hwrite;
        st_next.wr_addr = i_haddr[7:0];
        if (acc && !i_hwrite)
        begin
            st_next.hrdata = {24'h000000, rd_val(i_haddr[7:0], st_next,
                lo_if.pin_sync, hi_if.pin_sync)};
        end
        st_next.bus_rdata = {hi_if.pin_sync, lo_if.pin_sync};
        st_next.hreadyout = 1'b1;
    end

    // Latches survive all resets but power-on; directions always reset
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            st_reg.wr_pend <= 1'b0;
            st_reg.wr_addr <= 8'h00;
            st_reg.mctl <= `BSG_MCTL_RST;
            st_reg.dir_lo <= `BSG_DIR_RST;
            st_reg.dir_hi <= `BSG_DIR_RST;
            st_reg.hrdata <= 32'h00000000;
            st_reg.bus_rdata <= 16'h0000;
            st_reg.hreadyout <= 1'b1;
            if (i_por)
            begin
                st_reg.lat_lo <= `BSG_LATCH_POR;
                st_reg.lat_hi <= `BSG_LATCH_POR;
            end
            resp_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            resp_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Port stages
    // ****************************************************************
    // Both ports follow the one bus disable bit
    always_comb
    begin
        lo_if.gpio = st_reg.mctl[`BSG_MCTL_EXT_BUS_DISABLE];
        hi_if.gpio = st_reg.mctl[`BSG_MCTL_EXT_BUS_DISABLE];
        lo_if.dir = st_reg.dir_lo;
        lo_if.lat = st_reg.lat_lo;
        hi_if.dir = st_reg.dir_hi;
        hi_if.lat = st_reg.lat_hi;
        {lo_if.bus_oe, lo_if.bus_dout} = bus_lane(1'b0, i_bus_wide,
            i_bus_ale, i_bus_addr, i_bus_wdata, i_bus_data_oe);
        {hi_if.bus_oe, hi_if.bus_dout} = bus_lane(1'b1, i_bus_wide,
            i_bus_ale, i_bus_addr, i_bus_wdata, i_bus_data_oe);
    end

    bsg_port u_low
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .ifc(lo_if.port),
        .i_pin(i_low_port_pin_n),
        .o_pin(o_low_port_pin_n),
        .o_pin_oe(o_low_port_pin_n_oe)
    );

    bsg_port u_high
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .ifc(hi_if.port),
        .i_pin(i_high_port_pin_n),
        .o_pin(o_high_port_pin_n),
        .o_pin_oe(o_high_port_pin_n_oe)
    );

    assign o_hrdata = st_reg.hrdata;
    assign o_hreadyout = st_reg.hreadyout;
    assign o_hresp = resp_reg;
    assign o_bus_rdata = st_reg.bus_rdata;
    assign o_external_bus_disable = st_reg.mctl[`BSG_MCTL_EXT_BUS_DISABLE];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_lat_rd;
        acc && !i_hwrite && i_haddr[7:0] == `BSG_OFS_LOW_LATCH;
    endsequence

    sequence s_pins_wr;
        acc && i_hwrite && i_haddr[7:0] == `BSG_OFS_LOW_PINS ##1 1'b1;
    endsequence

    AST_DIR_INPUT: assert property (
        (o_external_bus_disable && st_reg.dir_lo[0])
        |=> !o_low_port_pin_n_oe[0])
        else $error("input pin still driven");
    AST_DIR_OUTPUT: assert property (
        (o_external_bus_disable && !st_reg.dir_hi[3])
        |=> o_high_port_pin_n_oe[3] &&
        o_high_port_pin_n[3] == $past(st_reg.lat_hi[3]))
        else $error("output pin not driving latch");
    AST_LAT_READ: assert property (
        s_lat_rd |=> o_hrdata[7:0] == st_reg.lat_lo)
        else $error("latch read mismatch");
    AST_PIN_WRITE: assert property (
        s_pins_wr |=> st_reg.lat_lo == $past(i_hwdata[7:0]))
        else $error("pin write did not reach latch");
    AST_MUX_DATA: assert property (
        (!o_external_bus_disable && i_bus_wide && !i_bus_ale &&
        i_bus_data_oe) |=> o_low_port_pin_n == $past(i_bus_wdata[7:0]) &&
        o_high_port_pin_n == $past(i_bus_wdata[15:8]))
        else $error("bus data lanes wrong");
    AST_ADDR_ONLY: assert property (
        (!o_external_bus_disable && !i_bus_wide) |=>
        &o_high_port_pin_n_oe &&
        o_high_port_pin_n == $past(i_bus_addr[15:8]))
        else $error("address byte not on high port");
    AST_RESET_BUS: assert property (
        ($rose(i_nrst) && !i_bus_wide) |-> !o_external_bus_disable
        ##1 &o_low_port_pin_n_oe)
        else $error("pins not on system bus after reset");
    AST_RESET_DIR: assert property (
        $rose(i_nrst) |-> st_reg.dir_lo == `BSG_DIR_RST &&
        st_reg.dir_hi == `BSG_DIR_RST)
        else $error("direction not all ones after reset");
    AST_MCTL_ZERO: assert property (
        st_reg.mctl[3:2] == 2'b00)
        else $error("unimplemented control bits set");
    AST_MCTL_READ: assert property (
        (acc && !i_hwrite && i_haddr[7:0] == `BSG_OFS_MEM_CTRL)
        |=> o_hrdata[3:2] == 2'b00)
        else $error("unimplemented control bits read back");
    AST_HIGH_INPUT: assert property (
        (o_external_bus_disable && st_reg.dir_hi[7])
        |=> !o_high_port_pin_n_oe[7])
        else $error("high input pin still driven");

    // Pin reads share the synchroniser with the bus read path,
    // so both must agree one edge after the address phase
    AST_PIN_READ: assert property (
        (acc && !i_hwrite && i_haddr[7:0] == `BSG_OFS_LOW_PINS)
        |=> o_hrdata[7:0] == o_bus_rdata[7:0])
        else $error("pin read differs from synchronised level");

    // Bus lanes follow the bus controller whatever the direction bits say
    AST_MUX_ADDR: assert property (
        (!o_external_bus_disable && i_bus_wide && i_bus_ale)
        |=> &o_low_port_pin_n_oe && &o_high_port_pin_n_oe &&
        o_low_port_pin_n == $past(i_bus_addr[7:0]))
        else $error("address phase not on both ports");
    AST_DATA_RELEASE: assert property (
        (!o_external_bus_disable && i_bus_wide && !i_bus_ale &&
        !i_bus_data_oe) |=> o_low_port_pin_n_oe == 8'h00 &&
        o_high_port_pin_n_oe == 8'h00)
        else $error("data lanes not released");
    AST_ADDR_LOW: assert property (
        (!o_external_bus_disable && !i_bus_wide) |=>
        &o_low_port_pin_n_oe &&
        o_low_port_pin_n == $past(i_bus_addr[7:0]))
        else $error("address byte not on low port");
endmodule

// >>> verilog/bsg_pkg.sv
/*
 * Types shared by the bus shared GPIO port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bsg_pkg;

    typedef logic [7:0] bsg_byte_t;

    // State of one port pin stage
    typedef struct packed {
        bsg_byte_t pin_o;
        bsg_byte_t pin_oe;
        bsg_byte_t sync1;
        bsg_byte_t sync2;
    } bsg_port_s;

    // State of the register block and bus slave
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        bsg_byte_t mctl;
        bsg_byte_t dir_lo;
        bsg_byte_t lat_lo;
        bsg_byte_t dir_hi;
        bsg_byte_t lat_hi;
        logic [31:0] hrdata;
        logic [15:0] bus_rdata;
        logic hreadyout;
    } bsg_top_s;

endpackage

// >>> verilog/bsg_port.sv
/*
 * One 8-bit port pin stage: selects GPIO or system bus drive, registers
 * pin output and enable, and synchronises the pin levels.
 * Assumes the pins are asynchronous to i_clk.
 */
`timescale 1ns/10ps

module bsg_port
(
    input wire logic i_clk,
    input wire logic i_nrst,
    bsg_port_if.port ifc,
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin,
    output logic [7:0] o_pin_oe
);
    import bsg_pkg::*;

    bsg_port_s st_reg;
    bsg_port_s st_next;

    // ****************************************************************
    // Drive selection
    // ****************************************************************
    // Bus owns the pins unless GPIO mode; registers are left untouched
    always_comb
    begin
        st_next = st_reg;
        if (ifc.gpio)
        begin
            st_next.pin_oe = ~ifc.dir;
            st_next.pin_o = ifc.lat;
        end
        else
        begin
            st_next.pin_oe = ifc.bus_oe;
            st_next.pin_o = ifc.bus_dout;
        end
        st_next.sync1 = i_pin;
        st_next.sync2 = st_reg.sync1;
    end

    // Pins float during reset so nothing fights an external driver
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_pin = st_reg.pin_o;
    assign o_pin_oe = st_reg.pin_oe;
    assign ifc.pin_sync = st_reg.sync2;
endmodule

// >>> verilog/bsg_port_if.sv
/*
 * Interface between the register block and one 8-bit port pin stage.
 * Assumes one clock domain on both sides.
 */
`timescale 1ns/10ps

interface bsg_port_if;
    logic [7:0] dir;
    logic [7:0] lat;
    logic gpio;
    logic [7:0] bus_dout;
    logic [7:0] bus_oe;
    logic [7:0] pin_sync;

    modport ctrl
    (
        output dir,
        output lat,
        output gpio,
        output bus_dout,
        output bus_oe,
        input pin_sync
    );

    modport port
    (
        input dir,
        input lat,
        input gpio,
        input bus_dout,
        input bus_oe,
        output pin_sync
    );
endinterface

// >>> verilog/bsg_regs.svh
/*
 * Register offsets, field positions, reset values and bus constants of
 * the bus shared GPIO ports.
 * Assumes inclusion by bare name from files under verilog/.
 */
`ifndef BSG_REGS_SVH
`define BSG_REGS_SVH

// ****************************************************************
// Register byte offsets on the AHB-Lite slave
// ****************************************************************
`define BSG_OFS_LOW_PINS 8'h00
`define BSG_OFS_LOW_LATCH 8'h04
`define BSG_OFS_LOW_DIR 8'h08
`define BSG_OFS_HIGH_PINS 8'h0c
`define BSG_OFS_HIGH_LATCH 8'h10
`define BSG_OFS_HIGH_DIR 8'h14
`define BSG_OFS_MEM_CTRL 8'h18

// ****************************************************************
// Memory bus control fields and reset values
// ****************************************************************
`define BSG_MCTL_EXT_BUS_DISABLE 7
`define BSG_MCTL_WMASK 8'hf3
`define BSG_MCTL_RST 8'h00
`define BSG_DIR_RST 8'hff
`define BSG_LATCH_POR 8'h00

// ****************************************************************
// AHB-Lite encodings
// ****************************************************************
`define BSG_HTRANS_NONSEQ 2'h2
`define BSG_HTRANS_ACTIVE_BIT 1

`endif
